// ===== bench/testbench.sv
// self-checking bench joining the two-wire master to the gamma reference slave
`timescale 1ns/1ps
`include "gamma_twowire_params.svh"
module testbench;
  import gamma_twowire_pkg::*;
  logic             clk_in = 1'b0;
  logic             rst_n_in = 1'b0;
  logic             cmd_valid = 1'b0;
  master_cmd_t      cmd = CMD_STOP;
  logic [7:0]       data = 8'h00;
  logic             a0 = 1'b0;
  logic             bank = 1'b0;
  logic             prog = 1'b0;
  logic             cmd_ready, done, acked, hs, act_bank;
  logic [21:0][9:0] gamma;
  logic [1:0][9:0]  common_voltage_output;
  logic [4:0]       used_seen;
  logic [23:0][9:0] exp_codes, shadow;
  logic [23:0][9:0] nvm [2];
  logic [4:0]       used [2];
  logic [31:0]      seed = 32'h000105e5;
  int               n_fail = 0;
  int               samples_checked = 0;
  twowire_if bus ();
  gamma_twowire_master #(.HALF(8)) i_gamma_twowire_master (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .ce_in(1'b1), .bus(bus.master_mp), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .data_in(data), .cmd_ready_out(cmd_ready), .done_out(done),
    .acked_out(acked));
  gamma_twowire_slave i_gamma_twowire_slave (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .bus(bus.slave_mp), .address_select_pin_in(a0), .bank_select_pin_in(bank),
    .nvm_program_in(prog), .gamma_code_out(gamma), .common_voltage_output_out(common_voltage_output),
    .active_bank_out(act_bank), .nvm_writes_used_out(used_seen), .high_speed_mode_out(hs));
  twowire_asserts i_twowire_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl(bus.scl),
    .sda(bus.sda), .master_scl_out(bus.master_scl_out), .master_scl_oe(bus.master_scl_oe),
    .master_sda_out(bus.master_sda_out), .slave_sda_out(bus.slave_sda_out),
    .slave_sda_oe(bus.slave_sda_oe));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  task automatic final_report;
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [239:0] e, input logic [239:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // request held from a falling edge until a rising edge sees ready
  task automatic issue(input master_cmd_t c, input logic [7:0] d);
    @(negedge clk_in);
    cmd_valid = 1'b1;
    cmd = c;
    data = d;
    @(posedge clk_in);
    for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++) @(posedge clk_in);
    @(negedge clk_in);
    cmd_valid = 1'b0;
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk_in);
    // a command that never completes counts as a mismatch, never a silent skip
    check("done", 240'(1), 240'(done));
  endtask : issue
  task automatic xfer(input logic [7:0] b, input logic e);
    issue(CMD_WRITE, b);
    @(negedge clk_in);
    check("ack", 240'(e), 240'(acked));
  endtask : xfer
  task automatic show;
    repeat (6) @(negedge clk_in);
    check("codes", exp_codes, {common_voltage_output, gamma});
  endtask : show
  task automatic wr(input logic [5:0] p, input logic [15:0] d);
    issue(CMD_START, 8'h00);
    xfer({`GW_ADDR_FIXED, a0, 1'b0}, 1'b1);
    xfer({2'b00, p}, 1'b1);
    xfer(d[15:8], 1'b1);
    xfer(d[7:0], 1'b1);
    issue(CMD_STOP, 8'h00);
    shadow[p] = d[9:0];
    if (d[15]) exp_codes = shadow;
    show();
  endtask : wr
  task automatic reload;
    exp_codes = (used[bank] != 5'h00) ? nvm[bank] : {24{`GW_CODE_RESET}};
    shadow = exp_codes;
  endtask : reload
  task automatic prog_once;
    @(negedge clk_in);
    prog = 1'b1;
    @(negedge clk_in);
    prog = 1'b0;
    if (used[bank] < `GW_NVM_WRITES) begin
      nvm[bank] = exp_codes;
      used[bank]++;
    end
    repeat (4) @(negedge clk_in);
    check("nvm writes", 240'(used[bank]), 240'(used_seen));
  endtask : prog_once
  task automatic set_bank(input logic b);
    bank = b;
    repeat (12) @(negedge clk_in);
    reload();
    check("bank", 240'(b), 240'(act_bank));
    show();
  endtask : set_bank
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end
  initial begin
    used[0] = 5'h00;
    used[1] = 5'h00;
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    reload();
    show();
    for (int k = 0; k < 2; k++) begin
      a0 = k[0];
      repeat (8) @(negedge clk_in);
      issue(CMD_START, 8'h00);
      xfer({`GW_ADDR_FIXED, ~a0, 1'b0}, 1'b0);
      xfer(8'h00, 1'b0);
      issue(CMD_START, 8'h00);
      xfer({`GW_ADDR_FIXED, a0, 1'b1}, 1'b0);
      issue(CMD_START, 8'h00);
      xfer({`GW_ADDR_FIXED, a0, 1'b0}, 1'b1);
      xfer(8'h18, 1'b0);
      issue(CMD_STOP, 8'h00);
    end
    wr(6'h00, 16'h83ff);
    wr(`GW_LAST_CH, 16'h7d55);
    for (int k = 0; k < 10; k++) begin
      seed = xorshift(seed);
      wr(6'(seed[4:0] % 24), {seed[9], seed[14:10], seed[31:22]});
    end
    issue(CMD_START, 8'h00);
    xfer(`GW_GCALL_ADDR, 1'b1);
    xfer(8'h05, 1'b0);
    issue(CMD_START, 8'h00);
    xfer(`GW_GCALL_ADDR, 1'b1);
    xfer(`GW_GCALL_RESET, 1'b1);
    issue(CMD_STOP, 8'h00);
    reload();
    show();
    seed = xorshift(seed);
    issue(CMD_START, 8'h00);
    xfer({`GW_HS_PREFIX, seed[2:0]}, 1'b0);
    issue(CMD_START, 8'h00);
    check("high speed", 240'(1), 240'(hs));
    xfer({`GW_ADDR_FIXED, a0, 1'b0}, 1'b1);
    issue(CMD_STOP, 8'h00);
    repeat (8) @(negedge clk_in);
    check("high speed", 240'(0), 240'(hs));
    wr(6'h03, 16'h8123);
    prog_once();
    wr(6'h04, 16'h8234);
    set_bank(1'b1);
    set_bank(1'b0);
    for (int k = 0; k < 17; k++) prog_once();
    final_report();
  end
endmodule : testbench

// ===== bench/twowire_asserts.sv
// concurrent checks on the open-drain two-wire link between master and slave
`timescale 1ns/1ps
module twowire_asserts (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic master_scl_out,
  input wire logic master_scl_oe,
  input wire logic master_sda_out,
  input wire logic slave_sda_out,
  input wire logic slave_sda_oe
);
  // ack may stand for its low half, the ninth pulse and the slave's filter delay
  localparam int ACK_MAX = 80;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bits;
  logic       framed;
  wire        start_c = scl & scl_q & sda_q & ~sda;
  wire        stop_c = scl & scl_q & ~sda_q & sda;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // bit slots counted 1..9 from the last start
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) bits <= 4'h0;
    else if (start_c) bits <= 4'h0;
    else if (scl & ~scl_q) bits <= (bits == 4'h9) ? 4'h1 : bits + 4'h1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) framed <= 1'b0;
    else if (start_c) framed <= 1'b1;
    else if (stop_c) framed <= 1'b0;
  end
  a_scl_input_only: assert property (scl == ~master_scl_oe)
    else $error("clock line level not set by the master alone");
  a_open_drain_low: assert property (!master_scl_out && !master_sda_out && !slave_sda_out)
    else $error("a driver drives a high level");
  a_ack_ninth_slot: assert property ($rose(slave_sda_oe) |-> bits == 4'h8 && !scl)
    else $error("acknowledge outside the ninth slot");
  a_ack_covers_rise: assert property ($rose(slave_sda_oe) |-> ##[1:ACK_MAX] ($rose(scl) && slave_sda_oe))
    else $error("acknowledge not held over the ninth pulse");
  a_ack_release_bound: assert property ($rose(slave_sda_oe) |-> ##[1:ACK_MAX] !slave_sda_oe)
    else $error("acknowledge not released");
  a_ack_stable_high: assert property (scl && scl_q |-> $stable(slave_sda_oe))
    else $error("slave changed data while clock high");
  a_idle_released: assert property (!framed |-> !slave_sda_oe)
    else $error("slave pulls data outside a frame");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  cover property ($rose(slave_sda_oe));
  cover property (start_c && framed);
  cover property (stop_c);
endmodule : twowire_asserts

// ===== logic/gamma_twowire_master.sv
// two-wire bus master end that drives the gamma reference slave
`timescale 1ns/1ps
`include "gamma_twowire_params.svh"
module gamma_twowire_master #(
  parameter int unsigned HALF = `GW_SCL_HALF
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          ce_in,
  twowire_if.master_mp                       bus,
  input  wire logic                          cmd_valid_in,
  input  wire gamma_twowire_pkg::master_cmd_t cmd_in,
  input  wire logic [7:0]                    data_in,
  output logic                               cmd_ready_out,
  output logic                               done_out,
  output logic                               acked_out
);
  import gamma_twowire_pkg::*;

  master_state_t state;
  logic [1:0]    phase;
  logic [3:0]    bitn;
  logic [15:0]   tick;
  logic [7:0]    sh;
  logic          scl_oe;
  logic          sda_oe;
  logic [2:0]    sync;
  logic          sda_f;

  wire tick_end = tick == 16'(HALF - 1);

  // sda from the slave passes three flops before it is trusted
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync  <= 3'h7;
      sda_f <= 1'b1;
    end else if (ce_in) begin
      sync <= {sync[1:0], bus.sda};
      if (sync[1] == sync[2]) begin
        sda_f <= sync[2];
      end
    end
  end

  assign cmd_ready_out = (state == MS_IDLE) || (state == MS_HELD);

  // clock, start and stop are all generated here
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= MS_IDLE;
      phase     <= 2'h0;
      bitn      <= 4'h0;
      tick      <= 16'h0000;
      sh        <= 8'hff;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      done_out  <= 1'b0;
      acked_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (cmd_ready_out) begin
        tick  <= 16'h0000;
        phase <= 2'h0;
        if (cmd_valid_in) begin
          unique case (cmd_in)
            CMD_START: begin
              state  <= MS_START;
              sda_oe <= 1'b0;
            end
            CMD_WRITE: begin
              // a write without a start is dropped
              if (state == MS_HELD) begin
                state <= MS_BIT;
                bitn  <= 4'h0;
                sh    <= data_in;
              end
            end
            CMD_STOP: begin
              if (state == MS_HELD) begin
                state <= MS_STOP;
              end
            end
            default: begin
            end
          endcase
        end
      end else if (!tick_end) begin
        tick <= tick + 16'h0001;
      end else begin
        tick  <= 16'h0000;
        phase <= phase + 2'h1;
        unique case (state)
          MS_START: begin
            // data falls with clock high, then clock low
            if (phase == 2'h1) begin
              scl_oe <= 1'b0;
            end else if (phase == 2'h2) begin
              sda_oe <= 1'b1;
            end else if (phase == 2'h3) begin
              scl_oe   <= 1'b1;
              state    <= MS_HELD;
              done_out <= 1'b1;
            end
          end
          MS_BIT: begin
            // data changes only in the middle of the low phase
            if (phase == 2'h0) begin
              sda_oe <= ~sh[7];
            end else if (phase == 2'h1) begin
              scl_oe <= 1'b0;
            end else begin
              scl_oe <= 1'b1;
              phase  <= 2'h0;
              if (bitn == 4'h8) begin
                acked_out <= ~sda_f;
                state     <= MS_HELD;
                done_out  <= 1'b1;
              end else begin
                bitn <= bitn + 4'h1;
                sh   <= {sh[6:0], 1'b1};
              end
            end
          end
          MS_STOP: begin
            if (phase == 2'h0) begin
              sda_oe <= 1'b1;
            end else if (phase == 2'h1) begin
              scl_oe <= 1'b0;
            end else begin
              sda_oe   <= 1'b0;
              state    <= MS_IDLE;
              done_out <= 1'b1;
            end
          end
          default: begin
            state <= MS_IDLE;
          end
        endcase
      end
    end
  end

  // open drain, lines are only pulled low
  assign bus.master_scl_out = 1'b0;
  assign bus.master_scl_oe  = scl_oe;
  assign bus.master_sda_out = 1'b0;
  assign bus.master_sda_oe  = sda_oe;
endmodule : gamma_twowire_master

// ===== logic/gamma_twowire_params.svh
// timing counts, address constants and reset values of the two-wire gamma reference link
`ifndef GAMMA_TWOWIRE_PARAMS_SVH
`define GAMMA_TWOWIRE_PARAMS_SVH
`define GW_ADDR_FIXED     6'h3a
`define GW_GCALL_ADDR     8'h00
`define GW_GCALL_RESET    8'h06
`define GW_HS_PREFIX      5'h01
`define GW_GAMMA_CH       22
`define GW_COMMON_VOLTAGE_OUTPUT_CH        2
`define GW_CHANNELS       24
`define GW_LAST_CH        6'h17
`define GW_CODE_W         10
`define GW_CODE_RESET     10'h200
`define GW_NVM_WRITES     5'h10
`define GW_UPDATE_BIT     7
`define GW_SYNC_RST       4'h3
`define GW_CLK_PERIOD_NS  25
`define GW_SCL_PERIOD_NS  2500
`define GW_SCL_HALF       ((`GW_SCL_PERIOD_NS + 2 * `GW_CLK_PERIOD_NS - 1) / (2 * `GW_CLK_PERIOD_NS))
`endif

// ===== logic/gamma_twowire_pkg.sv
// types shared by both ends of the two-wire gamma reference link
package gamma_twowire_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_IGNORE
  } slave_state_t;
  typedef enum logic [1:0] {BK_POINTER, BK_HIGH, BK_LOW, BK_GCALL} byte_kind_t;
  typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_STOP} master_cmd_t;
  typedef enum logic [2:0] {MS_IDLE, MS_HELD, MS_START, MS_BIT, MS_STOP} master_state_t;
endpackage : gamma_twowire_pkg

// ===== logic/gamma_twowire_slave.sv
// two-wire slave end of the gamma and common-voltage reference generator
// What this block does
// - slave only, clock line never driven
// - master makes clock, start, stop
// - start is data fall while clock high
// - address bits sampled on rising clock edges
// - matching write address acknowledged in ninth pulse
// - eight bits then one acknowledge slot
// - sender keeps data steady while clock high
// - data change during clock high is condition
// - stop is data rise while clock high
// - lines open-drain, only pulled low
// - bank select high bank 1, low 0
// - address select pin sets address bit
// - 22 gamma plus two common codes, 10-bit
// - each nonvolatile bank written at most 16 times
// - address fixed upper six, low bit pin
// - general call 00h, 06h resets, others refused
// - high-speed code unacknowledged, mode until stop or general call reset
// - bit 15 updates outputs after 16th bit
`timescale 1ns/1ps
`include "gamma_twowire_params.svh"
module gamma_twowire_slave (
  input  wire logic                                   clk_in,
  input  wire logic                                   rst_n_in,
  input  wire logic                                   ce_in,
  twowire_if.slave_mp                                 bus,
  input  wire logic                                   address_select_pin_in,
  input  wire logic                                   bank_select_pin_in,
  input  wire logic                                   nvm_program_in,
  output logic [`GW_GAMMA_CH-1:0][`GW_CODE_W-1:0]     gamma_code_out,
  output logic [`GW_COMMON_VOLTAGE_OUTPUT_CH-1:0][`GW_CODE_W-1:0]      common_voltage_output_out,
  output logic                                        active_bank_out,
  output logic [4:0]                                  nvm_writes_used_out,
  output logic                                        high_speed_mode_out
);
  import gamma_twowire_pkg::*;

  localparam int unsigned CH       = `GW_CHANNELS;
  localparam logic [3:0]  SYNC_RST = `GW_SYNC_RST;

  logic [3:0]   raw;
  logic [3:0]   s1;
  logic [3:0]   s2;
  logic [3:0]   s3;
  logic [3:0]   filt;
  logic         scl_q;
  logic         sda_q;
  logic         bank_q;
  slave_state_t state;
  byte_kind_t   kind;
  logic [2:0]   bitcnt;
  logic [7:0]   shift;
  logic [7:0]   hi_byte;
  logic [4:0]   ptr;
  logic         byte_full;
  logic         ack_q;
  logic         sda_drive;
  logic         hs_mode;
  logic         wr_strobe;
  logic         gc_pulse;
  logic [`GW_CODE_W-1:0] buf_code [CH];
  logic [`GW_CODE_W-1:0] cur_code [CH];
  logic [`GW_CODE_W-1:0] nvm      [2][CH];
  logic [1:0]   nvm_prog;
  logic [4:0]   nvm_count [2];

  assign raw = {bank_select_pin_in, address_select_pin_in, bus.sda, bus.scl};

  // pins: three flops, a new level counts once stages two and three agree
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        s1[i]   <= SYNC_RST[i];
        s2[i]   <= SYNC_RST[i];
        s3[i]   <= SYNC_RST[i];
        filt[i] <= SYNC_RST[i];
      end else if (ce_in) begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          filt[i] <= s3[i];
        end
      end
    end
  end

  wire scl        = filt[0];
  wire sda        = filt[1];
  wire addr_sel   = filt[2];
  wire bank       = filt[3];
  wire scl_rise   = scl & ~scl_q;
  wire scl_fall   = ~scl & scl_q;
  wire start_cond = scl & scl_q & sda_q & ~sda;
  wire stop_cond  = scl & scl_q & ~sda_q & sda;
  wire [7:0] byte_now = {shift[6:0], sda};
  wire bank_change = bank ^ bank_q;

  // pin supplies the address low bit
  wire own_write  = (byte_now[7:1] == {`GW_ADDR_FIXED, addr_sel}) && !byte_now[0];
  wire gcall_addr = byte_now == `GW_GCALL_ADDR;
  wire hs_code    = byte_now[7:3] == `GW_HS_PREFIX;

  logic ack_want;
  always_comb begin
    ack_want = 1'b0;
    if (state == ST_ADDR) begin
      ack_want = own_write | gcall_addr;
    end else begin
      unique case (kind)
        BK_POINTER: ack_want = (byte_now[7:6] == 2'b00) && (byte_now[5:0] <= `GW_LAST_CH);
        BK_HIGH:    ack_want = 1'b1;
        BK_LOW:     ack_want = 1'b1;
        BK_GCALL:   ack_want = byte_now == `GW_GCALL_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      bank_q <= 1'b0;
    end else if (ce_in) begin
      scl_q  <= scl;
      sda_q  <= sda;
      bank_q <= bank;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= ST_IDLE;
      kind      <= BK_POINTER;
      bitcnt    <= 3'h0;
      shift     <= 8'h00;
      hi_byte   <= 8'h00;
      ptr       <= 5'h00;
      byte_full <= 1'b0;
      ack_q     <= 1'b0;
      sda_drive <= 1'b0;
      hs_mode   <= 1'b0;
      wr_strobe <= 1'b0;
      gc_pulse  <= 1'b0;
    end else if (ce_in) begin
      wr_strobe <= 1'b0;
      gc_pulse  <= 1'b0;
      // conditions take priority over data bits
      if (start_cond) begin
        state     <= ST_ADDR;
        bitcnt    <= 3'h0;
        byte_full <= 1'b0;
        sda_drive <= 1'b0;
      end else if (stop_cond) begin
        state     <= ST_IDLE;
        byte_full <= 1'b0;
        sda_drive <= 1'b0;
        hs_mode   <= 1'b0;
      end else if (scl_rise && (state == ST_ADDR || state == ST_DATA)) begin
        shift  <= byte_now;
        bitcnt <= bitcnt + 3'h1;
        if (bitcnt == 3'h7) begin
          byte_full <= 1'b1;
          ack_q     <= ack_want;
          if (state == ST_ADDR && hs_code) begin
            hs_mode <= 1'b1;
          end
        end
      end else if (scl_fall && byte_full) begin
        byte_full <= 1'b0;
        if (ack_q) begin
          // pull data low through the ninth pulse
          sda_drive <= 1'b1;
          state     <= (state == ST_ADDR) ? ST_ADDR_ACK : ST_DATA_ACK;
        end else begin
          // refused byte, stay off the bus until next start
          state <= ST_IGNORE;
        end
      end else if (scl_fall && (state == ST_ADDR_ACK || state == ST_DATA_ACK)) begin
        // release right after the acknowledge pulse
        sda_drive <= 1'b0;
        bitcnt    <= 3'h0;
        state     <= ST_DATA;
        if (state == ST_ADDR_ACK) begin
          kind <= (shift == `GW_GCALL_ADDR) ? BK_GCALL : BK_POINTER;
        end else begin
          unique case (kind)
            BK_POINTER: begin
              ptr  <= shift[4:0];
              kind <= BK_HIGH;
            end
            BK_HIGH: begin
              hi_byte <= shift;
              kind    <= BK_LOW;
            end
            BK_LOW: begin
              wr_strobe <= 1'b1;
              kind      <= BK_POINTER;
            end
            BK_GCALL: begin
              gc_pulse <= 1'b1;
              hs_mode  <= 1'b0;
              state    <= ST_IGNORE;
            end
          endcase
        end
      end
    end
  end

  // buffered and active code per channel
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < CH; i++) begin
        buf_code[i] <= `GW_CODE_RESET;
        cur_code[i] <= `GW_CODE_RESET;
      end
    end else if (ce_in) begin
      if (gc_pulse || bank_change) begin
        // reload from the selected bank, reset code if unprogrammed
        for (int i = 0; i < CH; i++) begin
          buf_code[i] <= nvm_prog[bank] ? nvm[bank][i] : `GW_CODE_RESET;
          cur_code[i] <= nvm_prog[bank] ? nvm[bank][i] : `GW_CODE_RESET;
        end
      end else if (wr_strobe) begin
        buf_code[ptr] <= {hi_byte[1:0], shift};
        // update bit moves all buffered codes to the outputs
        if (hi_byte[`GW_UPDATE_BIT]) begin
          for (int i = 0; i < CH; i++) begin
            cur_code[i] <= (i == int'(ptr)) ? {hi_byte[1:0], shift} : buf_code[i];
          end
        end
      end
    end
  end

  // memory contents here stand in for the nonvolatile cells, and reset clears them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nvm_prog <= 2'b00;
      for (int b = 0; b < 2; b++) begin
        nvm_count[b] <= 5'h00;
        for (int i = 0; i < CH; i++) begin
          nvm[b][i] <= `GW_CODE_RESET;
        end
      end
    end else if (ce_in) begin
      // refuse programming past the write limit
      if (nvm_program_in && nvm_count[bank] < `GW_NVM_WRITES) begin
        nvm_prog[bank]  <= 1'b1;
        nvm_count[bank] <= nvm_count[bank] + 5'h01;
        for (int i = 0; i < CH; i++) begin
          nvm[bank][i] <= cur_code[i];
        end
      end
    end
  end

  for (genvar i = 0; i < `GW_GAMMA_CH; i++) begin : g_gamma
    assign gamma_code_out[i] = cur_code[i];
  end
  for (genvar i = 0; i < `GW_COMMON_VOLTAGE_OUTPUT_CH; i++) begin : g_common_voltage_output
    assign common_voltage_output_out[i] = cur_code[`GW_GAMMA_CH + i];
  end

  assign active_bank_out     = bank;
  assign nvm_writes_used_out = nvm_count[bank];
  assign high_speed_mode_out = hs_mode;
  // open drain, only ever drives low
  assign bus.slave_sda_out   = 1'b0;
  assign bus.slave_sda_oe    = sda_drive;
endmodule : gamma_twowire_slave

// ===== logic/twowire_if.sv
// open-drain two-wire link joining the bus master and the gamma reference slave
`timescale 1ns/1ps
interface twowire_if;
  logic scl;
  logic sda;
  logic master_scl_out;
  logic master_scl_oe;
  logic master_sda_out;
  logic master_sda_oe;
  logic slave_sda_out;
  logic slave_sda_oe;
  // wired-and with pull-ups: a line is low while any driver enables a low
  assign scl = ~(master_scl_oe & ~master_scl_out);
  assign sda = ~((master_sda_oe & ~master_sda_out) | (slave_sda_oe & ~slave_sda_out));
  modport master_mp (
    input  scl,
    input  sda,
    output master_scl_out,
    output master_scl_oe,
    output master_sda_out,
    output master_sda_oe
  );
  modport slave_mp (
    input  scl,
    input  sda,
    output slave_sda_out,
    output slave_sda_oe
  );
endinterface : twowire_if
